// ===== shared/lldw_pkg.sv
package lldw_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W    = 18;
  localparam int ADDR_W    = 20;
  localparam int BANK_W    = 3;
  localparam int NUM_BANKS = 8;
  localparam int ROW_W     = 13;
  localparam int LAT_W     = 4;
  localparam int DUE_W     = 16;
  localparam int ARM_W     = 3;
  localparam int QPTR_W    = 3;
  localparam int QDEPTH    = 8;
  localparam int CNT_W     = 11;
  localparam int LEFT_W    = 6;

  // ****************************************************************
  // Mode load field positions and values after reset
  // ****************************************************************
  localparam int CFG_LSB     = 0;
  localparam int CFG_W       = 3;
  localparam int BURST_LSB   = 3;
  localparam int BURST_W     = 2;
  localparam int LOOP_EN_POS = 7;

  localparam logic [LAT_W-1:0]   READ_LAT_BASE = 4'h3;
  localparam logic [CFG_W-1:0]   CFG_RST       = 3'h0;
  localparam logic [BURST_W-1:0] BURST_RST     = 2'h1;
  localparam logic [BURST_W-1:0] BURST_CODE2   = 2'h0;
  localparam logic [BURST_W-1:0] BURST_CODE4   = 2'h1;
  localparam logic [BURST_W-1:0] BURST_CODE8   = 2'h2;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [1:0]           LOAD_RUN_MIN   = 2'h3;
  localparam logic [CNT_W-1:0]     LOCK_CYCLES    = 11'h400;
  localparam logic [CNT_W-1:0]     INIT_NOP_COUNT = 11'h400;
  localparam logic [NUM_BANKS-1:0] ALL_BANKS      = 8'hFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_NOP   = 3'b000,
    CMD_READ  = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_MODE_LOAD = 3'b011,
    CMD_BANK_REF  = 3'b100
  } lldw_cmd_t;

  typedef enum logic [1:0] {
    INIT_WAIT_LOAD = 2'b00,
    INIT_REFRESH  = 2'b01,
    INIT_READY    = 2'b10
  } lldw_init_t;

  typedef struct packed {
    logic              mask;
    logic [DATA_W-1:0] data;
  } lldw_beat_t;

  typedef struct packed {
    lldw_beat_t rise;
    lldw_beat_t fall;
  } lldw_pair_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } lldw_wreq_t;

  typedef struct packed {
    logic              valid;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
  } lldw_ref_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [2:0] pairs_of(input logic [BURST_W-1:0] burst);
    logic [2:0] p;
    p = 3'h1;
    case (burst)
      BURST_CODE4: p = 3'h2;
      BURST_CODE8: p = 3'h4;
      default:  p = 3'h1;
    endcase
    return p;
  endfunction

  function automatic logic [ARM_W-1:0] bin2gray(input logic [ARM_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [ARM_W-1:0] gray2bin(input logic [ARM_W-1:0] g);
    logic [ARM_W-1:0] b;
    b = g;
    for (int i = ARM_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ===== rtl/lldw_wcap.sv
`timescale 1ns/1ps
module lldw_wcap (
  input  wire logic                         wclk,
  input  wire logic                         rst_n,
  input  wire logic [lldw_pkg::ARM_W-1:0]   arm_gray,
  input  wire logic [2:0]                   burst_pairs,
  input  wire logic [lldw_pkg::DATA_W-1:0]  wdata,
  input  wire logic                         wmask,
  output lldw_pkg::lldw_pair_t              slot0,
  output lldw_pkg::lldw_pair_t              slot1,
  output logic                              pair_tog
);

  // ****************************************************************
  // Crossings into the write data clock domain
  // ****************************************************************
  logic                          rst_s1_q, rst_s2_q;
  logic [lldw_pkg::ARM_W-1:0]    arm_s1_q, arm_s2_q;
  logic [2:0]                    bp_s1_q, bp_s2_q;

  always_ff @(posedge wclk) begin
    rst_s1_q <= rst_n;
    rst_s2_q <= rst_s1_q;
    arm_s1_q <= arm_gray;
    arm_s2_q <= arm_s1_q;
    bp_s1_q  <= burst_pairs;
    bp_s2_q  <= bp_s1_q;
  end

  // ****************************************************************
  // Falling edge half of each pair
  // ****************************************************************
  lldw_pkg::lldw_beat_t fall_q;

  always_ff @(negedge wclk) begin
    fall_q <= '{mask: wmask, data: wdata};
  end

  // ****************************************************************
  // Rising edge capture and pair publish
  // ****************************************************************
  logic [lldw_pkg::ARM_W-1:0]  seen_q, seen_d;
  logic [lldw_pkg::LEFT_W-1:0] left_q, left_d;
  lldw_pkg::lldw_beat_t        rise_q, rise_d;
  logic                        have_q, have_d;
  lldw_pkg::lldw_pair_t        slot0_q, slot0_d, slot1_q, slot1_d;
  logic                        tog_q, tog_d;

  always_comb begin
    logic add;
    logic take;
    add     = 1'b0;
    take    = 1'b0;
    seen_d  = seen_q;
    left_d  = left_q;
    rise_d  = rise_q;
    have_d  = 1'b0;
    slot0_d = slot0_q;
    slot1_d = slot1_q;
    tog_d   = tog_q;
    add     = (lldw_pkg::gray2bin(arm_s2_q) != seen_q);
    take    = (left_q != '0);
    // One armed burst per edge; its pairs start on the next rising edge
    if (add) begin
      seen_d = seen_q + 1'b1;
    end
    left_d = left_q - {{(lldw_pkg::LEFT_W-1){1'b0}}, take}
           + (add ? {3'h0, bp_s2_q} : '0);
    if (take) begin
      rise_d = '{mask: wmask, data: wdata};
      have_d = 1'b1;
    end
    // Ping-pong slots keep each pair stable for two link cycles
    if (have_q) begin
      if (tog_q) begin
        slot1_d = '{rise: rise_q, fall: fall_q};
      end else begin
        slot0_d = '{rise: rise_q, fall: fall_q};
      end
      tog_d = ~tog_q;
    end
    if (!rst_s2_q) begin
      seen_d = '0;
      left_d = '0;
      have_d = 1'b0;
      tog_d  = 1'b0;
    end
  end

  always_ff @(posedge wclk) begin
    seen_q  <= seen_d;
    left_q  <= left_d;
    rise_q  <= rise_d;
    have_q  <= have_d;
    slot0_q <= slot0_d;
    slot1_q <= slot1_d;
    tog_q   <= tog_d;
  end

  assign slot0    = slot0_q;
  assign slot1    = slot1_q;
  assign pair_tog = tog_q;

endmodule

// ===== rtl/lldw_refresh.sv
`timescale 1ns/1ps
module lldw_refresh (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clr,
  input  wire logic                         refresh_go,
  input  wire logic [lldw_pkg::BANK_W-1:0]  refresh_bank,
  output lldw_pkg::lldw_ref_t               ref_out
);

  // ****************************************************************
  // Per-bank row counters
  // ****************************************************************
  logic [lldw_pkg::ROW_W-1:0] row_q [lldw_pkg::NUM_BANKS];
  logic [lldw_pkg::ROW_W-1:0] row_d [lldw_pkg::NUM_BANKS];
  lldw_pkg::lldw_ref_t        ref_q, ref_d;

  always_comb begin
    row_d       = row_q;
    ref_d       = '0;
    if (refresh_go) begin
      // Address pins never reach this path
      ref_d.valid         = 1'b1;
      ref_d.bank          = refresh_bank;
      ref_d.row           = row_q[refresh_bank];
      row_d[refresh_bank] = row_q[refresh_bank] + 1'b1;
    end
    if (!rst_n || clr) begin
      for (int b = 0; b < lldw_pkg::NUM_BANKS; b++) begin
        row_d[b] = '0;
      end
      ref_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    row_q <= row_d;
    ref_q <= ref_d;
  end

  assign ref_out = ref_q;

endmodule

// ===== rtl/lldw_top.sv
`timescale 1ns/1ps
module lldw_top (
  input  wire logic                         CORE_CLK,
  input  wire logic                         RST_N,
  input  wire logic                         WRITE_DATA_CLOCK,
  input  wire logic                         CMD_SEL_N,
  input  wire logic                         CMD_WE_N,
  input  wire logic                         CMD_REF_N,
  input  wire logic [lldw_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [lldw_pkg::BANK_W-1:0]  BANK,
  input  wire logic [lldw_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                         WRITE_DATA_MASK,
  output logic                              WR_VALID,
  output logic [lldw_pkg::BANK_W-1:0]       WR_BANK,
  output logic [lldw_pkg::ADDR_W-1:0]       WR_ADDR,
  output logic [lldw_pkg::DATA_W-1:0]       WR_DATA,
  output logic                              REF_VALID,
  output logic [lldw_pkg::BANK_W-1:0]       REF_BANK,
  output logic [lldw_pkg::ROW_W-1:0]        REF_ROW,
  output logic                              INIT_DONE,
  output logic                              LOOP_LOCKED,
  output logic [lldw_pkg::LAT_W-1:0]        WRITE_LATENCY_CYCLES
);

  // ****************************************************************
  // Command decode
  // ****************************************************************
  lldw_pkg::lldw_cmd_t cmd;

  always_comb begin
    cmd = lldw_pkg::CMD_NOP;
    if (!CMD_SEL_N) begin
      unique case ({CMD_WE_N, CMD_REF_N})
        2'b00: cmd = lldw_pkg::CMD_MODE_LOAD;
        2'b01: cmd = lldw_pkg::CMD_WRITE;
        2'b10: cmd = lldw_pkg::CMD_BANK_REF;
        2'b11: cmd = lldw_pkg::CMD_READ;
      endcase
    end
  end

  // ****************************************************************
  // Mode load, internal reset, loop lock and initialization
  // ****************************************************************
  logic [lldw_pkg::CFG_W-1:0]     cfg_q, cfg_d;
  logic [lldw_pkg::BURST_W-1:0]   burst_q, burst_d;
  logic                           loop_en_q, loop_en_d;
  logic [lldw_pkg::CNT_W-1:0]     lock_cnt_q, lock_cnt_d;
  logic                           locked_q, locked_d;
  logic [1:0]                     load_run_q, load_run_d;
  logic [lldw_pkg::ADDR_W-1:0]    last_load_q, last_load_d;
  lldw_pkg::lldw_init_t           init_q, init_d;
  logic [lldw_pkg::CNT_W-1:0]     nop_cnt_q, nop_cnt_d;
  logic [lldw_pkg::NUM_BANKS-1:0] done_banks_q, done_banks_d;
  logic                           soft_rst;

  always_comb begin
    logic                        load;
    logic [lldw_pkg::ADDR_W-1:0] src;
    load         = 1'b0;
    src          = ADDR;
    cfg_d        = cfg_q;
    burst_d      = burst_q;
    loop_en_d    = loop_en_q;
    lock_cnt_d   = lock_cnt_q;
    locked_d     = locked_q;
    load_run_d   = load_run_q;
    last_load_d  = last_load_q;
    init_d       = init_q;
    nop_cnt_d    = nop_cnt_q;
    done_banks_d = done_banks_q;
    // Run is only known complete when a non-load command follows
    soft_rst     = (cmd != lldw_pkg::CMD_MODE_LOAD) &&
                   (load_run_q == lldw_pkg::LOAD_RUN_MIN);
    if (cmd == lldw_pkg::CMD_MODE_LOAD) begin
      last_load_d = ADDR;
      if (load_run_q != lldw_pkg::LOAD_RUN_MIN) begin
        load_run_d = load_run_q + 2'h1;
      end
      load = (init_q != lldw_pkg::INIT_WAIT_LOAD);
    end else begin
      load_run_d = 2'h0;
    end
    if (soft_rst) begin
      load   = 1'b1;
      src    = last_load_q;
    end
    // Loop lock counts while enabled; a low load drops the lock
    if (loop_en_q && !locked_q) begin
      lock_cnt_d = lock_cnt_q + 1'b1;
      locked_d   = (lock_cnt_q == lldw_pkg::LOCK_CYCLES - 1'b1);
    end
    if (load) begin
      cfg_d     = src[lldw_pkg::CFG_LSB +: lldw_pkg::CFG_W];
      burst_d   = src[lldw_pkg::BURST_LSB +: lldw_pkg::BURST_W];
      loop_en_d = src[lldw_pkg::LOOP_EN_POS];
      if (!src[lldw_pkg::LOOP_EN_POS] || !loop_en_q || soft_rst) begin
        lock_cnt_d = '0;
        locked_d   = 1'b0;
      end
    end
    unique case (init_q)
      lldw_pkg::INIT_WAIT_LOAD: begin
      end
      lldw_pkg::INIT_REFRESH: begin
        if (cmd == lldw_pkg::CMD_NOP && nop_cnt_q != lldw_pkg::INIT_NOP_COUNT) begin
          nop_cnt_d = nop_cnt_q + 1'b1;
        end
        if (cmd == lldw_pkg::CMD_BANK_REF) begin
          done_banks_d[BANK] = 1'b1;
        end
        if (nop_cnt_q == lldw_pkg::INIT_NOP_COUNT && done_banks_q == lldw_pkg::ALL_BANKS) begin
          init_d = lldw_pkg::INIT_READY;
        end
      end
      lldw_pkg::INIT_READY: begin
      end
      default: init_d = lldw_pkg::INIT_WAIT_LOAD;
    endcase
    if (soft_rst) begin
      init_d       = lldw_pkg::INIT_REFRESH;
      nop_cnt_d    = '0;
      done_banks_d = '0;
    end
    if (!RST_N) begin
      cfg_d        = lldw_pkg::CFG_RST;
      burst_d      = lldw_pkg::BURST_RST;
      loop_en_d    = 1'b0;
      lock_cnt_d   = '0;
      locked_d     = 1'b0;
      load_run_d   = 2'h0;
      last_load_d  = '0;
      init_d       = lldw_pkg::INIT_WAIT_LOAD;
      nop_cnt_d    = '0;
      done_banks_d = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    cfg_q        <= cfg_d;
    burst_q      <= burst_d;
    loop_en_q    <= loop_en_d;
    lock_cnt_q   <= lock_cnt_d;
    locked_q     <= locked_d;
    load_run_q   <= load_run_d;
    last_load_q  <= last_load_d;
    init_q       <= init_d;
    nop_cnt_q    <= nop_cnt_d;
    done_banks_q <= done_banks_d;
  end

  // ****************************************************************
  // Write scheduling and pending address queue
  // ****************************************************************
  logic [lldw_pkg::LAT_W-1:0]  wr_lat;
  logic [lldw_pkg::DUE_W-1:0]  due_q, due_d;
  logic [lldw_pkg::ARM_W-1:0]  arm_bin_q, arm_bin_d, arm_gray_q, arm_gray_d;
  logic [2:0]                  pairs_q, pairs_d;
  lldw_pkg::lldw_wreq_t        wq_q [lldw_pkg::QDEPTH];
  lldw_pkg::lldw_wreq_t        wq_d [lldw_pkg::QDEPTH];
  logic [lldw_pkg::QPTR_W-1:0] wr_ptr_q, wr_ptr_d;

  assign wr_lat = lldw_pkg::LAT_W'(cfg_q) + lldw_pkg::READ_LAT_BASE + 4'h1;

  always_comb begin
    due_d      = {due_q[lldw_pkg::DUE_W-2:0], cmd == lldw_pkg::CMD_WRITE};
    arm_bin_d  = arm_bin_q;
    wq_d       = wq_q;
    wr_ptr_d   = wr_ptr_q;
    pairs_d    = lldw_pkg::pairs_of(burst_q);
    if (due_q[wr_lat - 4'h1]) begin
      arm_bin_d = arm_bin_q + 1'b1;
    end
    arm_gray_d = lldw_pkg::bin2gray(arm_bin_d);
    if (cmd == lldw_pkg::CMD_WRITE) begin
      wq_d[wr_ptr_q] = '{bank: BANK, addr: ADDR};
      wr_ptr_d       = wr_ptr_q + 1'b1;
    end
    if (!RST_N) begin
      due_d      = '0;
      arm_bin_d  = '0;
      arm_gray_d = '0;
      wr_ptr_d   = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    due_q      <= due_d;
    arm_bin_q  <= arm_bin_d;
    arm_gray_q <= arm_gray_d;
    pairs_q    <= pairs_d;
    wq_q       <= wq_d;
    wr_ptr_q   <= wr_ptr_d;
  end

  // ****************************************************************
  // Link capture and word commit
  // ****************************************************************
  lldw_pkg::lldw_pair_t        slot0, slot1;
  logic                        pair_tog;
  logic                        tog_s1_q, tog_s2_q;
  logic                        tog_seen_q, tog_seen_d;
  lldw_pkg::lldw_beat_t        fall_hold_q, fall_hold_d;
  logic                        fall_pend_q, fall_pend_d;
  logic [lldw_pkg::QPTR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic [2:0]                  beat_q, beat_d;
  logic                        wr_valid_q, wr_valid_d;
  logic [lldw_pkg::BANK_W-1:0] wr_bank_q, wr_bank_d;
  logic [lldw_pkg::ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [lldw_pkg::DATA_W-1:0] wr_data_q, wr_data_d;

  lldw_wcap u_wcap (
    .wclk        (WRITE_DATA_CLOCK),
    .rst_n       (RST_N),
    .arm_gray    (arm_gray_q),
    .burst_pairs (pairs_q),
    .wdata       (WDATA),
    .wmask       (WRITE_DATA_MASK),
    .slot0       (slot0),
    .slot1       (slot1),
    .pair_tog    (pair_tog)
  );

  always_ff @(posedge CORE_CLK) begin
    tog_s1_q <= pair_tog;
    tog_s2_q <= tog_s1_q;
  end

  always_comb begin
    logic                 emit;
    lldw_pkg::lldw_beat_t beat;
    lldw_pkg::lldw_pair_t pair;
    emit        = 1'b0;
    beat        = fall_hold_q;
    pair        = tog_seen_q ? slot1 : slot0;
    tog_seen_d  = tog_seen_q;
    fall_hold_d = fall_hold_q;
    fall_pend_d = 1'b0;
    rd_ptr_d    = rd_ptr_q;
    beat_d      = beat_q;
    if (fall_pend_q) begin
      emit = 1'b1;
    end else if (tog_s2_q != tog_seen_q) begin
      // Slot is stable for two link cycles after its toggle
      tog_seen_d  = ~tog_seen_q;
      beat        = pair.rise;
      fall_hold_d = pair.fall;
      fall_pend_d = 1'b1;
      emit        = 1'b1;
    end
    wr_valid_d = emit && !beat.mask;
    wr_bank_d  = wq_q[rd_ptr_q].bank;
    wr_addr_d  = wq_q[rd_ptr_q].addr + lldw_pkg::ADDR_W'(beat_q);
    wr_data_d  = beat.data;
    if (emit) begin
      // Masked words still use up their address slot
      // Last word index is twice the pair count less one; 8 words end at 7
      if (beat_q == 3'({pairs_q, 1'b0} - 4'h1)) begin
        beat_d   = 3'h0;
        rd_ptr_d = rd_ptr_q + 1'b1;
      end else begin
        beat_d   = beat_q + 3'h1;
      end
    end
    if (!RST_N) begin
      tog_seen_d  = 1'b0;
      fall_pend_d = 1'b0;
      rd_ptr_d    = '0;
      beat_d      = 3'h0;
      wr_valid_d  = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    tog_seen_q  <= tog_seen_d;
    fall_hold_q <= fall_hold_d;
    fall_pend_q <= fall_pend_d;
    rd_ptr_q    <= rd_ptr_d;
    beat_q      <= beat_d;
    wr_valid_q  <= wr_valid_d;
    wr_bank_q   <= wr_bank_d;
    wr_addr_q   <= wr_addr_d;
    wr_data_q   <= wr_data_d;
  end

  // ****************************************************************
  // Refresh
  // ****************************************************************
  lldw_pkg::lldw_ref_t ref_out;

  lldw_refresh u_refresh (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .clr       (soft_rst),
    .refresh_go   (cmd == lldw_pkg::CMD_BANK_REF),
    .refresh_bank (BANK),
    .ref_out   (ref_out)
  );

  assign WR_VALID             = wr_valid_q;
  assign WR_BANK              = wr_bank_q;
  assign WR_ADDR              = wr_addr_q;
  assign WR_DATA              = wr_data_q;
  assign REF_VALID            = ref_out.valid;
  assign REF_BANK             = ref_out.bank;
  assign REF_ROW              = ref_out.row;
  assign INIT_DONE            = (init_q == lldw_pkg::INIT_READY);
  assign LOOP_LOCKED          = locked_q;
  assign WRITE_LATENCY_CYCLES = wr_lat;

endmodule

// ===== tb/lldw_top_assertions.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module lldw_top_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        CMD_SEL_N,
  input wire logic        CMD_WE_N,
  input wire logic        CMD_REF_N,
  input wire logic [19:0] ADDR,
  input wire logic [2:0]  BANK,
  input wire logic        WR_VALID,
  input wire logic [19:0] WR_ADDR,
  input wire logic        REF_VALID,
  input wire logic [2:0]  REF_BANK,
  input wire logic [12:0] REF_ROW,
  input wire logic        INIT_DONE,
  input wire logic        LOOP_LOCKED,
  input wire logic [3:0]  WRITE_LATENCY_CYCLES
);
  logic        mode_ld;
  logic        bank_ref;
  logic [11:0] since_d;
  logic [11:0] since_q;
  logic [1:0]  run_q;
  logic [7:0]  seen_q;
  logic [12:0] last_row_q [8];
  assign mode_ld  = !CMD_SEL_N && !CMD_WE_N && !CMD_REF_N;
  assign bank_ref = !CMD_SEL_N && CMD_WE_N && !CMD_REF_N;
  // Saturates so a long idle never wraps under the lock figure
  always_comb since_d = mode_ld ? 12'h000 : since_q + {11'h000, ~&since_q};
  always_ff @(posedge CORE_CLK) since_q <= RST_N ? since_d : 12'h000;
  // Mirror of the per-bank row counters; a finished load run clears it
  always_ff @(posedge CORE_CLK) begin
    run_q <= (RST_N && mode_ld) ? run_q + {1'b0, run_q != 2'h3} : 2'h0;
    if (!RST_N || (!mode_ld && run_q == 2'h3)) begin
      seen_q <= 8'h00;
    end else if (REF_VALID) begin
      seen_q[REF_BANK]     <= 1'b1;
      last_row_q[REF_BANK] <= REF_ROW;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_run;
    mode_ld [*3] ##1 !mode_ld;
  endsequence
  ref_pulse_a: assert property (bank_ref |=> REF_VALID && REF_BANK == $past(BANK))
    else $error("refresh not reported");
  ref_single_a: assert property (!bank_ref |=> !REF_VALID)
    else $error("stray refresh report");
  ref_row_step_a: assert property (REF_VALID && seen_q[REF_BANK] |->
    REF_ROW == last_row_q[REF_BANK] + 13'h0001)
    else $error("refresh row did not step");
  lat_load_a: assert property (s_run |=> {16'h0000, WRITE_LATENCY_CYCLES} ==
    ($past(ADDR, 2) & 20'h00007) + 20'h00004) else $error("write latency wrong");
  init_clear_a: assert property (s_run |=> !INIT_DONE)
    else $error("load run did not restart init");
  init_wait_a: assert property ($rose(INIT_DONE) |-> since_q >= 12'h400)
    else $error("init done too early");
  lock_wait_a: assert property ($rose(LOOP_LOCKED) |-> since_q >= 12'h400)
    else $error("loop locked too early");
  wr_addr_step_a: assert property (WR_VALID && $past(WR_VALID) |->
    WR_ADDR == $past(WR_ADDR) + 20'h00001) else $error("write address did not step");
  rst_clear_a: assert property ($rose(RST_N) |->
    !WR_VALID && !REF_VALID && !INIT_DONE && !LOOP_LOCKED) else $error("reset state wrong");
endmodule

bind lldw_top lldw_top_chk u_chk (.*);

// ===== tb/lldw_link_model.sv
`timescale 1ns/1ps
// ****
// Write data source
// ****
module lldw_link_model (
  input wire logic                 wclk,
  input wire logic                 en,
  input wire lldw_pkg::lldw_beat_t rise_beat,
  input wire lldw_pkg::lldw_beat_t fall_beat,
  output logic [17:0]              wdata,
  output logic                     wmask
);
  logic [18:0] idle_q = 19'h00000;
  initial {wmask, wdata} = 19'h00000;
  // Word set half a period ahead of its edge; idle words repeat only at the start, where the first two are both 0
  always @(wclk) begin
    {wmask, wdata} <= en ? (wclk ? fall_beat : rise_beat) : idle_q;
    idle_q <= ~idle_q + {18'h00000, wclk};
  end
endmodule

// ===== tb/lldw_top_tb.sv
`timescale 1ns/1ps
module lldw_top_tb;
  // ****
  // Bench
  // ****
  logic        CORE_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        WRITE_DATA_CLOCK = 1'b0;
  logic        CMD_SEL_N = 1'b1;
  logic        CMD_WE_N = 1'b1;
  logic        CMD_REF_N = 1'b1;
  logic [19:0] ADDR = 20'h00000;
  logic [2:0]  BANK = 3'h0;
  logic [17:0] WDATA, WR_DATA;
  logic        WRITE_DATA_MASK, WR_VALID, REF_VALID, INIT_DONE, LOOP_LOCKED;
  logic [19:0] WR_ADDR;
  logic [2:0]  WR_BANK, REF_BANK;
  logic [12:0] REF_ROW;
  logic [3:0]  WRITE_LATENCY_CYCLES;
  logic [18:0] rise_b = 19'h00000, fall_b = 19'h00000;
  logic        link_en = 1'b0;
  logic [31:0] seed = 32'hD402E38D;
  logic [31:0] r;
  logic [12:0] row_m [8];
  logic [40:0] wr_exp [$], wr_got [$], ref_exp [$], ref_got [$];
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  localparam int ROW_GAP    = 8;     // Row cycle stand-in, arbitrary
  localparam int STABLE_CYC = 40000; // 200 us of idle at 5 ns

  // Period never changes, so the delay loop needs no reset
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  initial begin
    #3.1;
    forever #6 WRITE_DATA_CLOCK = ~WRITE_DATA_CLOCK;
  end

  lldw_top dut (.*);
  lldw_link_model link (.wclk(WRITE_DATA_CLOCK), .en(link_en), .rise_beat(rise_b),
                        .fall_beat(fall_b), .wdata(WDATA), .wmask(WRITE_DATA_MASK));

  // Whole run is about 44000 cycles; ceiling leaves a third more
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (WR_VALID === 1'b1) wr_got.push_back({WR_BANK, WR_ADDR, WR_DATA});
    if (REF_VALID === 1'b1) ref_got.push_back({25'h0000000, REF_BANK, REF_ROW});
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic cmp(input logic [40:0] got, input logic [40:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_q(ref logic [40:0] e [$], ref logic [40:0] g [$]);
    cmp(g.size(), e.size());
    while (e.size() > 0 && g.size() > 0) cmp(g.pop_front(), e.pop_front());
    e.delete();
    g.delete();
  endtask

  // Command codes: 7 idle, 0 mode load, 1 write, 2 refresh, 3 read
  task automatic cmd(input logic [2:0] c, input logic [19:0] a, input logic [2:0] b);
    @(negedge CORE_CLK);
    {CMD_SEL_N, CMD_WE_N, CMD_REF_N} = c;
    ADDR = a;
    BANK = b;
  endtask

  task automatic nops(input int n);
    repeat (n) cmd(3'h7, 20'h00000, 3'h0);
  endtask

  task automatic refr(input logic [2:0] b);
    logic [31:0] x;
    x = rnd();
    cmd(3'h2, x[19:0], b);
    ref_exp.push_back({25'h0000000, b, row_m[b]});
    row_m[b] = row_m[b] + 13'h0001;
  endtask

  task automatic init(input logic [2:0] cfg, input logic [1:0] bsel);
    cmd(3'h0, 20'h00000, 3'h0);
    cmd(3'h0, 20'h00000, 3'h0);
    cmd(3'h0, {12'h000, 1'b1, 2'h0, bsel, cfg}, 3'h0);
    nops(1);
    foreach (row_m[i]) row_m[i] = 13'h0000;
    for (int i = 7; i >= 0; i--) refr(i[2:0]);
    nops(1000);
    if (bsel == 2'h0) cmp(LOOP_LOCKED, 1'b0);
    nops(20);
    cmp(INIT_DONE, 1'b0);
    nops(8);
    cmp(INIT_DONE, 1'b1);
    cmp(LOOP_LOCKED, 1'b1);
    cmp(WRITE_LATENCY_CYCLES, cfg + 4'h4);
    cmp_q(ref_exp, ref_got);
  endtask

  task automatic wr(input logic [1:0] bsel, input logic mr, input logic mf);
    logic [31:0] a;
    a = rnd();
    rise_b = {mr, a[17:0]};
    fall_b = {mf, ~a[17:0]};
    link_en = 1'b1;
    cmd(3'h1, a[19:0], a[22:20]);
    cmd(3'h3, ~a[19:0], ~a[22:20]);
    nops(50);
    link_en = 1'b0;
    for (int k = 0; k < (2 << bsel); k++) begin
      if (!(k[0] ? mf : mr)) begin
        wr_exp.push_back({a[22:20], a[19:0] + k[19:0], k[0] ? ~a[17:0] : a[17:0]});
      end
    end
    cmp_q(wr_exp, wr_got);
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST_N = 1'b1;
    nops(STABLE_CYC);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      init(r[2:0], i[1:0]);
      wr(i[1:0], 1'b0, 1'b0);
      wr(i[1:0], 1'b1, 1'b0);
      wr(i[1:0], r[3], r[4]);
      refr(r[7:5]);
      nops(ROW_GAP);
      refr(r[7:5]);
      nops(ROW_GAP);
      refr(r[10:8]);
      nops(2);
      cmp_q(ref_exp, ref_got);
    end
    wrap_up();
  end
endmodule
